// [axis_homing_sequencer_regs.svh]
// Purpose: Parameter numbers, field positions and reset values of the homing sequencer.
// Assumes: Parameter numbers are 10 bits wide.
// Notes: Definitions only.
`ifndef AXIS_HOMING_SEQUENCER_REGS_SVH
`define AXIS_HOMING_SEQUENCER_REGS_SVH
`define AHS_PN_MODE 10'h080
`define AHS_PN_METHOD 10'h0b3
`define AHS_PN_OFFSET 10'h0b5
`define AHS_PN_SW_SPEED 10'h0b7
`define AHS_PN_IX_SPEED 10'h0b9
`define AHS_PN_RAMP 10'h0bb
`define AHS_PN_CUR_LEVEL 10'h0bd
`define AHS_PN_CUR_TIME 10'h0bf
`define AHS_PN_CMD 10'h21c
`define AHS_PN_STATUS 10'h29c
`define AHS_PN_MODE_RB 10'h29e
`define AHS_MODE_HOMING 8'h06
`define AHS_CMD_START 4
`define AHS_CMD_HALT 8
`define AHS_ST_DONE 10
`define AHS_ST_ATTAINED 12
`define AHS_ST_ERROR 13
`define AHS_M_NEG_STOP 8'hef
`define AHS_M_POS_STOP 8'hee
`define AHS_M_HERE 8'h23
`define AHS_CUR_TIME_RESET 32'h000003e8
`endif

// [ahs_pkg.sv]
// Purpose: Types shared by the homing sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in the register header.
package ahs_pkg;
  typedef enum logic [2:0] {
    AHS_IDLE = 3'b000,
    AHS_SEEKA = 3'b001,
    AHS_SEEKB = 3'b011,
    AHS_INDEX = 3'b010,
    AHS_CURRENT = 3'b110,
    AHS_STOP = 3'b111
  } ahs_state_t;
  typedef enum logic [1:0] {
    AHS_K_BAD = 2'h0,
    AHS_K_EDGE = 2'h1,
    AHS_K_INDEX = 2'h2,
    AHS_K_CURRENT = 2'h3
  } ahs_kind_t;
  typedef struct packed {
    ahs_kind_t kind;
    logic [1:0] sigSel;
    logic finalDir;
    logic startLevel;
    logic useIndex;
    logic here;
  } ahs_cfg_t;
endpackage

// [axis_homing_sequencer.sv]
// Purpose: Homing-mode sequencer: seeks a reference, then loads the home offset.
// Assumes: Axis inputs synchronous to core_clk; moveDir high means rightward (positive).
// Notes: Functional notes below.
// Functional notes
// - Methods one to thirty-five fix signal, direction.
// - Method 1: left, index right of negative-limit edge.
// - Method 2: right, index left of positive-limit edge.
// - Methods 3-6: direction from home switch level.
// - Reverse anywhere after home switch changes.
// - Methods 7-10 start right, 11-14 left.
// - Switch active at start: direction from edge.
// - Reverse at limit when moving away.
// - Methods 17-30 home on transition, no index.
// - Method 33 negative, 34 positive, first index.
// - Method 35 takes position, no motion.
// - Method -17 negative, home on current stop.
// - Method -18 positive, home on current stop.
// - Home offset separates home from zero.
// - Mode write immediate; motion by command word.
// - Command bit 4 starts, bit 8 halts.
// - Command bits 5 and 6 ignored.
// - Mode ends only at standstill after event.
// - Status bit 10 shows homing completed.
// - Status bit 12 shows homing successful.
// - Status bit 13 shows homing error.
`timescale 1ns/10ps
`include "axis_homing_sequencer_regs.svh"

module axis_homing_sequencer #(
  parameter int CURRENT_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic parWrite,
  input wire logic parRead,
  input wire logic [9:0] parameterNumber,
  input wire logic [31:0] parWrData,
  output logic [31:0] parRdData,
  output logic parRdValid,
  input wire logic negLimit,
  input wire logic posLimit,
  input wire logic homeSwitch,
  input wire logic indexPulse,
  input wire logic [CURRENT_WIDTH-1:0] motorCurrent,
  input wire logic motorStill,
  input wire logic quickStop,
  input wire logic faultStop,
  output logic moveEnable,
  output logic moveDir,
  output logic [31:0] moveSpeed,
  output logic [31:0] moveRamp,
  output logic positionLoad,
  output logic [31:0] positionLoadValue
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] method;
    logic [31:0] offset;
    logic [31:0] swSpeed;
    logic [31:0] ixSpeed;
    logic [31:0] ramp;
    logic [CURRENT_WIDTH-1:0] curLevel;
    logic [31:0] curTime;
    logic [15:0] cmd;
    logic prevStart;
    logic crossed;
    ahs_pkg::ahs_state_t state;
    ahs_pkg::ahs_cfg_t cfg;
    logic [31:0] cnt;
    logic success;
    logic attained;
    logic failed;
    logic moveEnable;
    logic moveDir;
    logic [31:0] moveSpeed;
    logic positionLoad;
    logic [31:0] rdData;
    logic rdValid;
  } ahs_regs_t;

  ahs_regs_t r;
  ahs_regs_t next_r;
  ahs_pkg::ahs_cfg_t startCfg;
  logic [15:0] statusWord;
  logic sigLevel;
  logic limitAhead;
  logic startEdge;
  logic stopReq;

  // Method table. Each entry names the signal, the direction of the final approach and the
  // signal level seen before the edge when moving that way.
  function automatic ahs_pkg::ahs_cfg_t method_cfg(input logic [7:0] m);
    ahs_pkg::ahs_cfg_t c;
    logic [7:0] b;
    c = '{kind: ahs_pkg::AHS_K_EDGE, sigSel: 2'h2, finalDir: 1'b0, startLevel: 1'b0,
          useIndex: 1'b1, here: 1'b0};
    b = m;
    if (m >= 8'h11 && m <= 8'h1e)
    begin
      b = m - 8'h10;
      c.useIndex = 1'b0;
    end
    unique case (b)
      8'h01: c = '{ahs_pkg::AHS_K_EDGE, 2'h0, 1'b1, 1'b1, c.useIndex, 1'b0};
      8'h02: c = '{ahs_pkg::AHS_K_EDGE, 2'h1, 1'b0, 1'b1, c.useIndex, 1'b0};
      8'h03: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b0, 1'b1, c.useIndex, 1'b0};
      8'h04: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b1, 1'b0, c.useIndex, 1'b0};
      8'h05: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b1, 1'b1, c.useIndex, 1'b0};
      8'h06: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b0, 1'b0, c.useIndex, 1'b0};
      8'h07, 8'h09: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b0, 1'b1, c.useIndex, 1'b0};
      8'h08, 8'h0a: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b1, 1'b0, c.useIndex, 1'b0};
      8'h0b, 8'h0d: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b1, 1'b1, c.useIndex, 1'b0};
      8'h0c, 8'h0e: c = '{ahs_pkg::AHS_K_EDGE, 2'h2, 1'b0, 1'b0, c.useIndex, 1'b0};
      8'h21: c = '{ahs_pkg::AHS_K_INDEX, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0};
      8'h22: c = '{ahs_pkg::AHS_K_INDEX, 2'h3, 1'b1, 1'b0, 1'b1, 1'b0};
      `AHS_M_HERE: c = '{ahs_pkg::AHS_K_INDEX, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1};
      `AHS_M_NEG_STOP: c = '{ahs_pkg::AHS_K_CURRENT, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0};
      `AHS_M_POS_STOP: c = '{ahs_pkg::AHS_K_CURRENT, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0};
      default: c.kind = ahs_pkg::AHS_K_BAD;
    endcase
    return c;
  endfunction

  // Decoded views of the axis inputs and of the command word.
  always_comb
  begin
    startCfg = method_cfg(r.method);
    unique case (r.cfg.sigSel)
      2'h0: sigLevel = negLimit;
      2'h1: sigLevel = posLimit;
      default: sigLevel = homeSwitch;
    endcase
    limitAhead = r.moveDir ? posLimit : negLimit;
    // Bits 5 and 6 take no part in any decode here.
    startEdge = r.cmd[`AHS_CMD_START] & ~r.prevStart;
    stopReq = r.cmd[`AHS_CMD_HALT] | quickStop | (r.mode != `AHS_MODE_HOMING);
    statusWord = 16'h0000;
    statusWord[`AHS_ST_DONE] = r.attained & (r.state == ahs_pkg::AHS_IDLE);
    statusWord[`AHS_ST_ATTAINED] = r.attained;
    statusWord[`AHS_ST_ERROR] = r.failed;
  end

  // Next-state logic for the parameter port and the homing sequence.
  always_comb
  begin
    next_r = r;
    next_r.positionLoad = 1'b0;
    next_r.rdValid = parRead;
    next_r.prevStart = r.cmd[`AHS_CMD_START];
    // A write lands at once; only the command word can set the axis moving.
    if (parWrite)
    begin
      unique case (parameterNumber)
        `AHS_PN_MODE: next_r.mode = parWrData[7:0];
        `AHS_PN_METHOD: next_r.method = parWrData[7:0];
        `AHS_PN_OFFSET: next_r.offset = parWrData;
        `AHS_PN_SW_SPEED: next_r.swSpeed = parWrData;
        `AHS_PN_IX_SPEED: next_r.ixSpeed = parWrData;
        `AHS_PN_RAMP: next_r.ramp = parWrData;
        `AHS_PN_CUR_LEVEL: next_r.curLevel = parWrData[CURRENT_WIDTH-1:0];
        `AHS_PN_CUR_TIME: next_r.curTime = parWrData;
        `AHS_PN_CMD: next_r.cmd = parWrData[15:0];
        default: next_r.cmd = r.cmd;
      endcase
    end
    if (parRead)
    begin
      unique case (parameterNumber)
        `AHS_PN_MODE, `AHS_PN_MODE_RB: next_r.rdData = {24'h000000, r.mode};
        `AHS_PN_METHOD: next_r.rdData = {24'h000000, r.method};
        `AHS_PN_OFFSET: next_r.rdData = r.offset;
        `AHS_PN_SW_SPEED: next_r.rdData = r.swSpeed;
        `AHS_PN_IX_SPEED: next_r.rdData = r.ixSpeed;
        `AHS_PN_RAMP: next_r.rdData = r.ramp;
        `AHS_PN_CUR_LEVEL: next_r.rdData = 32'(r.curLevel);
        `AHS_PN_CUR_TIME: next_r.rdData = r.curTime;
        `AHS_PN_CMD: next_r.rdData = {16'h0000, r.cmd};
        `AHS_PN_STATUS: next_r.rdData = {16'h0000, statusWord};
        default: next_r.rdData = 32'h00000000;
      endcase
    end
    next_r.moveSpeed = (r.state == ahs_pkg::AHS_INDEX) ? r.ixSpeed : r.swSpeed;
    unique case (r.state)
      ahs_pkg::AHS_IDLE:
      begin
        if (startEdge && r.mode == `AHS_MODE_HOMING)
        begin
          next_r.cfg = startCfg;
          next_r.attained = 1'b0;
          next_r.failed = 1'b0;
          next_r.success = 1'b0;
          next_r.cnt = 32'h00000000;
          next_r.moveDir = startCfg.finalDir;
          if (startCfg.kind == ahs_pkg::AHS_K_BAD)
          begin
            next_r.failed = 1'b1;
            next_r.state = ahs_pkg::AHS_STOP;
          end
          else if (startCfg.here)
          begin
            next_r.success = 1'b1;
            next_r.state = ahs_pkg::AHS_STOP;
          end
          else if (startCfg.kind == ahs_pkg::AHS_K_CURRENT)
          begin
            next_r.moveEnable = 1'b1;
            next_r.state = ahs_pkg::AHS_CURRENT;
          end
          else if (startCfg.kind == ahs_pkg::AHS_K_INDEX)
          begin
            next_r.moveEnable = 1'b1;
            next_r.state = ahs_pkg::AHS_INDEX;
          end
          else
          begin
            next_r.moveEnable = 1'b1;
            // Already past the edge: back off first, against the final direction.
            if (method_level(startCfg.sigSel) != startCfg.startLevel)
            begin
              next_r.moveDir = ~startCfg.finalDir;
              next_r.crossed = 1'b1;
              next_r.state = ahs_pkg::AHS_SEEKA;
            end
            else
            begin
              next_r.state = ahs_pkg::AHS_SEEKB;
            end
          end
        end
      end
      ahs_pkg::AHS_SEEKA:
      begin
        // After a reversal at a limit the switch must be crossed once, or the search
        // would bounce straight back into the limit it has just left.
        if (sigLevel != r.cfg.startLevel)
        begin
          next_r.crossed = 1'b1;
        end
        if (sigLevel == r.cfg.startLevel && r.crossed)
        begin
          next_r.moveDir = r.cfg.finalDir;
          next_r.state = ahs_pkg::AHS_SEEKB;
        end
        else if (limitAhead)
        begin
          next_r.failed = 1'b1;
          next_r.moveEnable = 1'b0;
          next_r.state = ahs_pkg::AHS_STOP;
        end
      end
      ahs_pkg::AHS_SEEKB:
      begin
        if (sigLevel != r.cfg.startLevel)
        begin
          if (r.cfg.useIndex)
          begin
            next_r.state = ahs_pkg::AHS_INDEX;
          end
          else
          begin
            next_r.success = 1'b1;
            next_r.moveEnable = 1'b0;
            next_r.state = ahs_pkg::AHS_STOP;
          end
        end
        else if (limitAhead && r.cfg.sigSel == 2'h2)
        begin
          next_r.moveDir = ~r.cfg.finalDir;
          next_r.crossed = 1'b0;
          next_r.state = ahs_pkg::AHS_SEEKA;
        end
        else if (limitAhead)
        begin
          next_r.failed = 1'b1;
          next_r.moveEnable = 1'b0;
          next_r.state = ahs_pkg::AHS_STOP;
        end
      end
      ahs_pkg::AHS_INDEX:
      begin
        if (indexPulse)
        begin
          next_r.success = 1'b1;
          next_r.moveEnable = 1'b0;
          next_r.state = ahs_pkg::AHS_STOP;
        end
        else if (limitAhead)
        begin
          next_r.failed = 1'b1;
          next_r.moveEnable = 1'b0;
          next_r.state = ahs_pkg::AHS_STOP;
        end
      end
      ahs_pkg::AHS_CURRENT:
      begin
        // The count restarts whenever current dips, so only a steady push counts.
        if (motorCurrent > r.curLevel)
        begin
          next_r.cnt = r.cnt + 32'h00000001;
        end
        else
        begin
          next_r.cnt = 32'h00000000;
        end
        if (motorCurrent > r.curLevel && r.cnt > r.curTime)
        begin
          next_r.success = 1'b1;
          next_r.moveEnable = 1'b0;
          next_r.state = ahs_pkg::AHS_STOP;
        end
        else if (limitAhead)
        begin
          next_r.failed = 1'b1;
          next_r.moveEnable = 1'b0;
          next_r.state = ahs_pkg::AHS_STOP;
        end
      end
      ahs_pkg::AHS_STOP:
      begin
        next_r.moveEnable = 1'b0;
        // The run is not closed until the motor has come to rest.
        if (motorStill)
        begin
          next_r.state = ahs_pkg::AHS_IDLE;
          next_r.attained = r.success & ~r.failed;
          next_r.positionLoad = r.success & ~r.failed;
        end
      end
    endcase
    // Halt, quick stop or a drive fault ends any run in motion; a fault counts as an error.
    if (r.state != ahs_pkg::AHS_IDLE && r.state != ahs_pkg::AHS_STOP && (stopReq || faultStop))
    begin
      next_r.moveEnable = 1'b0;
      next_r.success = 1'b0;
      next_r.failed = faultStop | next_r.failed;
      next_r.state = ahs_pkg::AHS_STOP;
    end
  end

  function automatic logic method_level(input logic [1:0] sel);
    logic v;
    v = (sel == 2'h0) ? negLimit : (sel == 2'h1) ? posLimit : homeSwitch;
    return v;
  endfunction

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.curTime <= `AHS_CUR_TIME_RESET;
      r.state <= ahs_pkg::AHS_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Every output is a plain view of the state register.
  assign parRdData = r.rdData;
  assign parRdValid = r.rdValid;
  assign moveEnable = r.moveEnable;
  assign moveDir = r.moveDir;
  assign moveSpeed = r.moveSpeed;
  assign moveRamp = r.ramp;
  assign positionLoad = r.positionLoad;
  assign positionLoadValue = r.offset;

endmodule

// [ahs_chk_asserts.sv]
// Purpose: Port-level checks of the homing sequencer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every sequencer instance.
`timescale 1ns/10ps
`include "axis_homing_sequencer_regs.svh"
module ahs_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic parWrite,
  input wire logic parRead,
  input wire logic [9:0] parameterNumber,
  input wire logic [31:0] parWrData,
  input wire logic [31:0] parRdData,
  input wire logic parRdValid,
  input wire logic motorStill,
  input wire logic quickStop,
  input wire logic moveEnable,
  input wire logic positionLoad
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Motion may only come from a start write two cycles earlier.
  start_cause_a: assert property ($rose(moveEnable) |-> $past(parWrite, 2) &&
    $past(parameterNumber, 2) == `AHS_PN_CMD && $past(parWrData[4], 2))
    else $error("motion began without a start write");
  halt_stops_a: assert property (moveEnable && parWrite && parameterNumber == `AHS_PN_CMD
    && parWrData[8] |-> ##[1:4] !moveEnable) else $error("halt did not stop motion");
  quick_stops_a: assert property (moveEnable && quickStop |-> ##[1:4] !moveEnable)
    else $error("quick stop did not stop motion");
  load_still_a: assert property (positionLoad |-> $past(motorStill) && !moveEnable)
    else $error("position loaded while moving");
  load_pulse_a: assert property (positionLoad |=> !positionLoad)
    else $error("position load longer than one cycle");
  read_answer_a: assert property (parRdValid == $past(parRead))
    else $error("read answer not one cycle after request");
  done_success_a: assert property (parRdValid && $past(parameterNumber) == `AHS_PN_STATUS
    |-> !parRdData[10] || parRdData[12]) else $error("done without success");
  err_exclusive_a: assert property (parRdValid && $past(parameterNumber) == `AHS_PN_STATUS
    |-> !(parRdData[12] && parRdData[13])) else $error("success and error together");
endmodule
bind axis_homing_sequencer ahs_chk u_chk (
  .core_clk(core_clk),
  .reset(reset),
  .parWrite(parWrite),
  .parRead(parRead),
  .parameterNumber(parameterNumber),
  .parWrData(parWrData),
  .parRdData(parRdData),
  .parRdValid(parRdValid),
  .motorStill(motorStill),
  .quickStop(quickStop),
  .moveEnable(moveEnable),
  .positionLoad(positionLoad)
);

// [ahs_fieldbus_model.sv]
// Purpose: Fieldbus controller model that reads and writes parameters.
// Assumes: The sequencer samples requests on the rising edge.
// Notes: Released lines show inverted values so stale data cannot pass.
`timescale 1ns/10ps
module ahs_fieldbus_model (
  input wire logic core_clk,
  output logic parWrite,
  output logic parRead,
  output logic [9:0] parameterNumber,
  output logic [31:0] parWrData,
  input wire logic [31:0] parRdData,
  input wire logic parRdValid
);
  initial
  begin
    parWrite = 1'b0;
    parRead = 1'b0;
    parameterNumber = 10'h3ff;
    parWrData = 32'hffffffff;
  end
  // One write, held over exactly one rising edge.
  task automatic wr(input logic [9:0] pn, input logic [31:0] d);
    @(negedge core_clk);
    parWrite = 1'b1;
    parameterNumber = pn;
    parWrData = d;
    @(negedge core_clk);
    parWrite = 1'b0;
    parameterNumber = ~pn;
    parWrData = ~d;
  endtask
  // One read; a missing answer returns unknowns so the caller's compare fails.
  task automatic rd(input logic [9:0] pn, output logic [31:0] d);
    @(negedge core_clk);
    parRead = 1'b1;
    parameterNumber = pn;
    @(negedge core_clk);
    parRead = 1'b0;
    parameterNumber = ~pn;
    d = parRdValid ? parRdData : 32'hxxxxxxxx;
  endtask
endmodule

// [axis_homing_sequencer_tb_top.sv]
// Purpose: Self-checking bench of the homing sequencer.
// Assumes: Axis inputs change at the falling edge.
// Notes: Threshold time is set small so current runs stay short.
`timescale 1ns/10ps
`include "axis_homing_sequencer_regs.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errTotal++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module axis_homing_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic parWrite, parRead, parRdValid, moveEnable, moveDir, positionLoad;
  logic negLimit = 1'b0, posLimit = 1'b0, homeSwitch = 1'b0, indexPulse = 1'b0;
  logic motorStill = 1'b0, quickStop = 1'b0, faultStop = 1'b0, d0;
  logic [9:0] parameterNumber;
  logic [31:0] parWrData, parRdData, moveSpeed, moveRamp, positionLoadValue;
  logic [15:0] motorCurrent = 16'h0000;
  logic [7:0] loads = 8'h00;
  int errTotal = 0, totalChecks = 0;
  always #2 core_clk = ~core_clk;
  axis_homing_sequencer u_dut (.core_clk(core_clk), .reset(reset), .parWrite(parWrite),
    .parRead(parRead), .parameterNumber(parameterNumber), .parWrData(parWrData),
    .parRdData(parRdData), .parRdValid(parRdValid), .negLimit(negLimit), .posLimit(posLimit),
    .homeSwitch(homeSwitch), .indexPulse(indexPulse), .motorCurrent(motorCurrent),
    .motorStill(motorStill), .quickStop(quickStop), .faultStop(faultStop),
    .moveEnable(moveEnable), .moveDir(moveDir), .moveSpeed(moveSpeed), .moveRamp(moveRamp),
    .positionLoad(positionLoad), .positionLoadValue(positionLoadValue));
  ahs_fieldbus_model u_bus (.core_clk(core_clk), .parWrite(parWrite), .parRead(parRead),
    .parameterNumber(parameterNumber), .parWrData(parWrData), .parRdData(parRdData),
    .parRdValid(parRdValid));
  // Count load pulses so a missing or doubled load shows up.
  always @(posedge core_clk)
  begin
    if (positionLoad === 1'b1)
      loads <= loads + 8'h01;
  end
  task automatic ck(input logic [9:0] pn, input logic [31:0] e);
    logic [31:0] d;
    u_bus.rd(pn, d);
    `CHK(d, e)
  endtask
  // Start a run; bits 5 and 6 ride along and must change nothing.
  task automatic go(input logic [7:0] m);
    u_bus.wr(`AHS_PN_CMD, 32'h0);
    u_bus.wr(`AHS_PN_METHOD, {24'h0, m});
    u_bus.wr(`AHS_PN_CMD, 32'h70);
    repeat (2) @(negedge core_clk);
  endtask
  // Wait for motion to end, report standstill, then check the status word.
  task automatic fin(input logic [31:0] st);
    int n;
    n = 0;
    while (moveEnable !== 1'b0 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    `CHK(moveEnable, 1'b0)
    motorStill = 1'b1;
    repeat (3) @(negedge core_clk);
    ck(`AHS_PN_STATUS, st);
    motorStill = 1'b0;
    $display("run ended at %0t", $time);
  endtask
  task automatic hlt;
    u_bus.wr(`AHS_PN_CMD, 32'h170);
    fin(32'h0);
  endtask
  task automatic closeOut;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard: far beyond the several hundred cycles the runs need.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    closeOut;
  end
  initial
  begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    u_bus.wr(`AHS_PN_MODE, 32'h6);
    ck(`AHS_PN_MODE_RB, 32'h6);
    u_bus.wr(`AHS_PN_OFFSET, 32'h12345678);
    u_bus.wr(`AHS_PN_SW_SPEED, 32'h11);
    u_bus.wr(`AHS_PN_IX_SPEED, 32'h22);
    u_bus.wr(`AHS_PN_RAMP, 32'h33);
    u_bus.wr(`AHS_PN_CUR_LEVEL, 32'h100);
    u_bus.wr(`AHS_PN_CUR_TIME, 32'h4);
    u_bus.wr(`AHS_PN_STATUS, 32'hffff);
    ck(`AHS_PN_STATUS, 32'h0);
    ck(10'h3f0, 32'h0);
    go(8'h01);
    `CHK({moveEnable, moveDir, moveSpeed, moveRamp}, {2'b10, 32'h11, 32'h33})
    negLimit = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(moveDir, 1'b1)
    negLimit = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK({moveEnable, moveSpeed}, {1'b1, 32'h22})
    indexPulse = 1'b1;
    @(negedge core_clk);
    indexPulse = 1'b0;
    fin(32'h1400);
    `CHK({loads, positionLoadValue, moveEnable}, {8'h01, 32'h12345678, 1'b0})
    go(8'h23);
    `CHK(moveEnable, 1'b0)
    fin(32'h1400);
    `CHK(loads, 8'h02)
    go(8'h02);
    `CHK({moveEnable, moveDir}, 2'b11)
    posLimit = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(moveDir, 1'b0)
    posLimit = 1'b0;
    repeat (2) @(negedge core_clk);
    indexPulse = 1'b1;
    @(negedge core_clk);
    indexPulse = 1'b0;
    fin(32'h1400);
    // Switch lies behind the start: bounce off the limit, cross the switch, come back.
    go(8'h08);
    posLimit = 1'b1;
    @(negedge core_clk);
    posLimit = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK({moveEnable, moveDir}, 2'b10)
    homeSwitch = 1'b1;
    repeat (2) @(negedge core_clk);
    homeSwitch = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(moveDir, 1'b1)
    homeSwitch = 1'b1;
    repeat (2) @(negedge core_clk);
    indexPulse = 1'b1;
    @(negedge core_clk);
    indexPulse = 1'b0;
    homeSwitch = 1'b0;
    fin(32'h1400);
    go(8'h11);
    `CHK({moveEnable, moveDir}, 2'b10)
    negLimit = 1'b1;
    repeat (3) @(negedge core_clk);
    negLimit = 1'b0;
    fin(32'h1400);
    go(8'h22);
    `CHK({moveEnable, moveDir}, 2'b11)
    hlt();
    go(8'h21);
    `CHK({moveEnable, moveDir}, 2'b10)
    quickStop = 1'b1;
    fin(32'h0);
    quickStop = 1'b0;
    go(8'h22);
    faultStop = 1'b1;
    fin(32'h2000);
    faultStop = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      go(i == 0 ? `AHS_M_NEG_STOP : `AHS_M_POS_STOP);
      motorCurrent = 16'h0200;
      repeat (3) @(negedge core_clk);
      `CHK({moveEnable, moveDir}, {1'b1, i[0]})
      fin(32'h1400);
      motorCurrent = 16'h0000;
    end
    for (int m = 7; m < 15; m++)
    begin
      go(m[7:0]);
      `CHK({moveEnable, moveDir}, {1'b1, m < 11})
      hlt();
      homeSwitch = 1'b1;
      go(m[7:0]);
      `CHK({moveEnable, moveDir}, {1'b1, m > 10})
      hlt();
      homeSwitch = 1'b0;
    end
    for (int m = 3; m < 7; m++)
    begin
      go(m[7:0]);
      d0 = moveDir;
      hlt();
      homeSwitch = 1'b1;
      go(m[7:0]);
      `CHK(moveDir, ~d0)
      hlt();
      homeSwitch = 1'b0;
    end
    for (int m = 0; m < 3; m++)
    begin
      go(m == 0 ? 8'h00 : m == 1 ? 8'h0f : 8'h24);
      fin(32'h2000);
    end
    u_bus.wr(`AHS_PN_MODE, 32'h1);
    go(8'h01);
    `CHK(moveEnable, 1'b0)
    closeOut;
  end
endmodule
